// ### logic/hbc_pkg.sv
package hbc_pkg;

   // timing base
   localparam int CLK_HZ       = 20_000_000;
   localparam int STARTUP_US   = 20;
   localparam int STARTUP_CYC  = (STARTUP_US * (CLK_HZ / 1_000_000));
   localparam int INT_OSC_HZ   = 920_000;
   localparam int INT_OSC_DIV  = (CLK_HZ + INT_OSC_HZ / 2) / INT_OSC_HZ;
   localparam int DEAD_NS      = 400;
   localparam int DEAD_CYC     = (DEAD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

   // chopping sequence, in oscillator ticks
   localparam logic [3:0] CHOP_LAST   = 4'hf;
   localparam logic [2:0] FAST_TICKS  = 3'h6;
   localparam logic [2:0] BLANK_LONG  = 3'h6;
   localparam logic [2:0] BLANK_SHORT = 3'h4;

   // register map
   localparam logic [11:0] ADDR_CTRL   = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam logic [7:0]  OSC_DIV_RST = 8'h1a;
   localparam logic [7:0]  OSC_DIV_MIN = 8'h02;

   // status field positions
   localparam int ST_FAULT   = 0;
   localparam int ST_SINGLE  = 2;
   localparam int ST_OSC_INT = 3;
   localparam int ST_STBY    = 4;
   localparam int ST_BOOT    = 5;
   localparam int ST_PHASE_A = 8;
   localparam int ST_PHASE_B = 10;

   // fault codes, numeric order is severity order
   typedef enum logic [1:0] {
      FLT_NONE = 2'b00,
      FLT_OPEN = 2'b01,
      FLT_OVC  = 2'b10,
      FLT_TEMP = 2'b11
   } hbc_fault_t;

   typedef enum logic [1:0] {
      PH_CHARGE = 2'b00,
      PH_FAST   = 2'b01,
      PH_SLOW   = 2'b10
   } hbc_phase_t;

   typedef struct packed {
      logic oe;
      logic val;
   } hbc_pin_t;

   typedef struct packed {
      hbc_pin_t pos;
      hbc_pin_t neg;
   } hbc_bridge_out_t;

   typedef struct packed {
      logic pwm;
      logic dir1;
      logic dir2;
   } hbc_bridge_in_t;

   typedef struct packed {
      logic [8:0]            boot_cnt;
      logic                  booting;
      logic                  first_boot;
      logic                  mode_single;
      logic                  osc_internal;
      logic                  stby;
      hbc_fault_t            fault;
      logic [7:0]            osc_div;
      logic [7:0]            osc_cnt;
      logic [3:0]            chop_cnt;
      hbc_phase_t [1:0]      phase;
      logic [1:0][2:0]       fast_cnt;
      logic [1:0][2:0]       blank_cnt;
      logic [1:0][1:0]       dir_prev;
      logic [1:0][3:0]       dead_cnt;
      hbc_bridge_out_t [1:0] out;
      logic                  pready;
      logic                  pslverr;
      logic [31:0]           prdata;
   } hbc_state_t;

endpackage

// ### logic/hbc_chop_control.sv
// Contract
// - blank detection on every direction input change
// - mode high: bridges paralleled, low: independent
// - mode sampled in the startup after power only, not after standby, then held
// - single mode: A inputs drive both bridges
// - dual mode: bridge B uses own inputs
// - pwm low: 00 hi-z, else short brake
// - pwm high: 00 off, 10/01 drive, 11 brake
// - standby when all relevant inputs low
// - flags released normally, pulled on faults
// - open load pulls second flag only
// - overcurrent pulls first flag only
// - over temperature pulls both flags
// - fault held until power or standby
// - oscillator source detected in startup window
// - chopping period is sixteen oscillator clocks
// - period cycles charge, fast, slow decay
// - charge until threshold, then fast decay
// - fast decay six clocks, then slow decay
// - late threshold keeps fast decay to end
// - blank six clocks if select high, else four
// - blanking starts at every charge phase
// - dead time about 400 ns between switchings
`timescale 1ns/1ps
module hbc_chop_control
   import hbc_pkg::*;
(
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        reset,
   // apb slave
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // control pins
   input  wire logic        bridge_mode_select,
   input  wire logic        osc_set_pin,
   input  wire logic        blank_length_select,
   input  wire logic        bridge_a_pwm,
   input  wire logic        bridge_a_dir1,
   input  wire logic        bridge_a_dir2,
   input  wire logic        bridge_b_pwm,
   input  wire logic        bridge_b_dir1,
   input  wire logic        bridge_b_dir2,
   // fault detectors and current comparators
   input  wire logic        over_temp_fault,
   input  wire logic        over_current_fault,
   input  wire logic        open_load_fault,
   input  wire logic [1:0]  current_threshold,
   // bridge outputs, value plus enable
   output logic             bridge_a_out_pos,
   output logic             bridge_a_out_pos_oe,
   output logic             bridge_a_out_neg,
   output logic             bridge_a_out_neg_oe,
   output logic             bridge_b_out_pos,
   output logic             bridge_b_out_pos_oe,
   output logic             bridge_b_out_neg,
   output logic             bridge_b_out_neg_oe,
   // open-drain fault flags
   output logic             fault_flag_first,
   output logic             fault_flag_first_oe,
   output logic             fault_flag_second,
   output logic             fault_flag_second_oe
);

   hbc_state_t state_reg;
   hbc_state_t state_next;

   // status word as software reads it
   function automatic logic [31:0] status_word(input hbc_state_t s);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[ST_FAULT +: 2]   = s.fault;
      w[ST_SINGLE]       = s.mode_single;
      w[ST_OSC_INT]      = s.osc_internal;
      w[ST_STBY]         = s.stby;
      w[ST_BOOT]         = s.booting;
      w[ST_PHASE_A +: 2] = s.phase[0];
      w[ST_PHASE_B +: 2] = s.phase[1];
      return w;
   endfunction

   // input decode to the wanted output state, chopping applied
   function automatic hbc_bridge_out_t decode(input hbc_bridge_in_t i, input hbc_phase_t ph);
      hbc_bridge_out_t o;
      o = '0;
      if (!i.pwm) begin
         if (i.dir1 || i.dir2) begin
            o = '{pos: '{1'b1, 1'b0}, neg: '{1'b1, 1'b0}};
         end
      end else begin
         case ({i.dir1, i.dir2})
            2'b10: o = '{pos: '{1'b1, 1'b1}, neg: '{1'b1, 1'b0}};
            2'b01: o = '{pos: '{1'b1, 1'b0}, neg: '{1'b1, 1'b1}};
            2'b11: o = '{pos: '{1'b1, 1'b0}, neg: '{1'b1, 1'b0}};
            default: o = '0;
         endcase
         if (i.dir1 != i.dir2) begin
            case (ph)
               PH_FAST: begin
                  o.pos.val = ~o.pos.val; // reverse drive returns current to supply
                  o.neg.val = ~o.neg.val;
               end
               PH_SLOW: begin
                  o.pos.val = 1'b0;
                  o.neg.val = 1'b0;
               end
               default: ;
            endcase
         end
      end
      return o;
   endfunction

   // next-state logic
   always_comb begin
      hbc_bridge_in_t  a_in;
      hbc_bridge_in_t  b_in;
      hbc_bridge_in_t  cur_in;
      hbc_bridge_out_t tgt;
      logic            idle;
      logic            tick;
      logic            wrap;
      logic            thr;
      logic [7:0]      div;
      logic [2:0]      blen;
      hbc_fault_t      code;
      state_next = state_reg;
      a_in       = '{bridge_a_pwm, bridge_a_dir1, bridge_a_dir2};
      b_in       = '{bridge_b_pwm, bridge_b_dir1, bridge_b_dir2};
      cur_in     = a_in;
      tgt        = '0;
      tick       = 1'b0;
      wrap       = 1'b0;
      thr        = 1'b0;
      blen       = blank_length_select ? BLANK_LONG : BLANK_SHORT;
      div        = 8'h00;
      code       = FLT_NONE;

      // apb: one wait state, then a one-cycle answer
      state_next.pready  = 1'b0;
      state_next.pslverr = 1'b0;
      if (psel && penable && !state_reg.pready) begin
         state_next.pready = 1'b1;
         case (paddr)
            ADDR_CTRL: begin
               if (pwrite) begin
                  state_next.osc_div = pwdata[7:0];
               end
               state_next.prdata = {24'h00_0000, state_reg.osc_div};
            end
            ADDR_STATUS: begin
               state_next.prdata = status_word(state_reg);
            end
            default: begin
               state_next.pslverr = 1'b1;
               state_next.prdata  = 32'h0000_0000;
            end
         endcase
      end

      // idle detection for standby
      if (state_reg.mode_single) begin
         idle = !(a_in.pwm || a_in.dir1 || a_in.dir2);
      end else begin
         idle = !(a_in.pwm || a_in.dir1 || a_in.dir2 || b_in.pwm || b_in.dir1 || b_in.dir2);
      end

      // startup window after power or after standby
      if (state_reg.booting) begin
         state_next.boot_cnt     = state_reg.boot_cnt + 9'h001;
         state_next.osc_internal = !osc_set_pin;
         if (state_reg.first_boot) begin
            state_next.mode_single = bridge_mode_select;
         end
         if (state_reg.boot_cnt == 9'(STARTUP_CYC - 1)) begin
            state_next.booting    = 1'b0;
            state_next.first_boot = 1'b0;
         end
      end else if (state_reg.stby) begin
         if (!idle) begin
            state_next.stby     = 1'b0;
            state_next.booting  = 1'b1;
            state_next.boot_cnt = 9'h000;
         end
      end else if (idle) begin
         state_next.stby  = 1'b1;
         state_next.fault = FLT_NONE;
      end

      // fault capture, the more severe code wins and sticks
      if (over_temp_fault) begin
         code = FLT_TEMP;
      end else if (over_current_fault) begin
         code = FLT_OVC;
      end else if (open_load_fault) begin
         code = FLT_OPEN;
      end
      if (!state_reg.stby && !state_reg.booting && code > state_reg.fault) begin
         state_next.fault = code;
      end

      // oscillator tick and chopping period counter
      div = state_reg.osc_internal ? 8'(INT_OSC_DIV) : state_reg.osc_div;
      if (div < OSC_DIV_MIN) begin
         div = OSC_DIV_MIN;
      end
      if (state_reg.stby || state_reg.booting) begin
         state_next.osc_cnt  = 8'h00;
         state_next.chop_cnt = 4'h0;
      end else if (state_reg.osc_cnt >= div - 8'h01) begin
         state_next.osc_cnt  = 8'h00;
         tick                = 1'b1;
         state_next.chop_cnt = state_reg.chop_cnt + 4'h1;
         wrap                = (state_reg.chop_cnt == CHOP_LAST);
      end else begin
         state_next.osc_cnt = state_reg.osc_cnt + 8'h01;
      end

      // per-bridge sequencer, output decode and dead time
      for (int b = 0; b < 2; b++) begin
         if (b == 1 && !state_reg.mode_single) begin
            cur_in = b_in;
            thr    = current_threshold[1];
         end else begin
            cur_in = a_in;
            thr    = current_threshold[0];
         end

         // blanking on direction edges and charge start
         state_next.dir_prev[b] = {cur_in.dir1, cur_in.dir2};
         if ({cur_in.dir1, cur_in.dir2} != state_reg.dir_prev[b]) begin
            state_next.blank_cnt[b] = blen;
         end else if (tick && state_reg.blank_cnt[b] != 3'h0) begin
            state_next.blank_cnt[b] = state_reg.blank_cnt[b] - 3'h1;
         end

         // chopping phases
         if (state_reg.stby || state_reg.booting) begin
            state_next.phase[b] = PH_CHARGE;
         end else if (wrap) begin
            state_next.phase[b]     = PH_CHARGE;
            state_next.blank_cnt[b] = blen;
         end else begin
            case (state_reg.phase[b])
               PH_CHARGE: begin
                  if (thr && state_reg.blank_cnt[b] == 3'h0) begin
                     state_next.phase[b]    = PH_FAST;
                     state_next.fast_cnt[b] = FAST_TICKS;
                  end
               end
               PH_FAST: begin
                  if (tick) begin
                     state_next.fast_cnt[b] = state_reg.fast_cnt[b] - 3'h1;
                     if (state_reg.fast_cnt[b] == 3'h1) begin
                        state_next.phase[b] = PH_SLOW;
                     end
                  end
               end
               PH_SLOW: ;
               default: state_next.phase[b] = PH_CHARGE;
            endcase
         end

         // wanted outputs, all off while idle, starting or faulted
         if (!(state_reg.stby || state_reg.booting || state_reg.fault != FLT_NONE)) begin
            tgt = decode(cur_in, state_reg.phase[b]);
         end else begin
            tgt = '0;
         end

         // pass through all-off for the dead time before a new drive
         // a pending dead time keeps running even if the target returns to off
         if (tgt == state_reg.out[b]) begin
            if (state_reg.dead_cnt[b] != 4'h0) begin
               state_next.dead_cnt[b] = state_reg.dead_cnt[b] - 4'h1;
            end
         end else if (state_reg.out[b].pos.oe || state_reg.out[b].neg.oe) begin
            state_next.out[b]      = '0;
            state_next.dead_cnt[b] = 4'(DEAD_CYC);
         end else if (state_reg.dead_cnt[b] != 4'h0) begin
            state_next.dead_cnt[b] = state_reg.dead_cnt[b] - 4'h1;
         end else begin
            state_next.out[b] = tgt;
         end
      end
   end

   // state register
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_reg            <= '0;
         state_reg.booting    <= 1'b1;
         state_reg.first_boot <= 1'b1;
         state_reg.osc_div    <= OSC_DIV_RST;
      end else begin
         state_reg <= state_next;
      end
   end

   // outputs straight from the state register
   assign prdata               = state_reg.prdata;
   assign pready               = state_reg.pready;
   assign pslverr              = state_reg.pslverr;
   assign bridge_a_out_pos     = state_reg.out[0].pos.val;
   assign bridge_a_out_pos_oe  = state_reg.out[0].pos.oe;
   assign bridge_a_out_neg     = state_reg.out[0].neg.val;
   assign bridge_a_out_neg_oe  = state_reg.out[0].neg.oe;
   assign bridge_b_out_pos     = state_reg.out[1].pos.val;
   assign bridge_b_out_pos_oe  = state_reg.out[1].pos.oe;
   assign bridge_b_out_neg     = state_reg.out[1].neg.val;
   assign bridge_b_out_neg_oe  = state_reg.out[1].neg.oe;

   // open drain flags: always drive low when enabled
   assign fault_flag_first     = 1'b0;
   assign fault_flag_second    = 1'b0;
   assign fault_flag_first_oe  = state_reg.fault[1];
   assign fault_flag_second_oe = state_reg.fault[0];

endmodule

// ### test/hbc_chop_control_assertions.sv
`timescale 1ns/1ps
module hbc_chop_control_checker (
   // clock, reset and bus answer
   input logic clk_sys,
   input logic reset,
   input logic psel,
   input logic penable,
   input logic pready,
   input logic pslverr,
   // bridge a pins
   input logic bridge_a_pwm,
   input logic bridge_a_dir1,
   input logic bridge_a_dir2,
   input logic bridge_a_out_pos,
   input logic bridge_a_out_pos_oe,
   input logic bridge_a_out_neg,
   input logic bridge_a_out_neg_oe,
   // faults and flags
   input logic over_temp_fault,
   input logic over_current_fault,
   input logic open_load_fault,
   input logic fault_flag_first,
   input logic fault_flag_first_oe,
   input logic fault_flag_second,
   input logic fault_flag_second_oe
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);
   logic a_act;
   // any bridge a input high keeps standby away
   assign a_act = bridge_a_pwm | bridge_a_dir1 | bridge_a_dir2;
   property p_wait; psel && penable && !pready |=> pready; endproperty
   a_wait: assert property (p_wait) else $error("no answer after one wait state");
   property p_err; pslverr |-> pready; endproperty
   a_err: assert property (p_err) else $error("error without ready");
   property p_flag_low; !fault_flag_first && !fault_flag_second; endproperty
   a_flag_low: assert property (p_flag_low) else $error("flag driven high");
   property p_open; $rose(fault_flag_second_oe) |-> $past(open_load_fault || over_temp_fault); endproperty
   a_open: assert property (p_open) else $error("second flag without cause");
   property p_ovc; $rose(fault_flag_first_oe) |-> $past(over_current_fault || over_temp_fault); endproperty
   a_ovc: assert property (p_ovc) else $error("first flag without cause");
   property p_both; fault_flag_first_oe && fault_flag_second_oe && a_act |=> fault_flag_first_oe
      && fault_flag_second_oe; endproperty
   a_both: assert property (p_both) else $error("temperature flags dropped");
   property p_hold; fault_flag_first_oe && a_act |=> fault_flag_first_oe; endproperty
   a_hold: assert property (p_hold) else $error("first flag dropped while active");
   property p_dead; $fell(bridge_a_out_pos_oe) |=> !bridge_a_out_pos_oe [*8]; endproperty
   a_dead: assert property (p_dead) else $error("dead time too short");
   property p_same; bridge_a_out_pos_oe && $past(bridge_a_out_pos_oe) |-> bridge_a_out_pos
      == $past(bridge_a_out_pos); endproperty
   a_same: assert property (p_same) else $error("drive flipped without dead time");
   property p_idle; !a_act |=> !bridge_a_out_pos_oe && !bridge_a_out_neg_oe; endproperty
   a_idle: assert property (p_idle) else $error("idle bridge not released");
   property p_brake; !bridge_a_pwm [*3] |-> !(bridge_a_out_pos_oe && bridge_a_out_pos); endproperty
   a_brake: assert property (p_brake) else $error("driven high with pwm low");
   property p_nohigh; !(bridge_a_out_pos_oe && bridge_a_out_pos && bridge_a_out_neg_oe
      && bridge_a_out_neg); endproperty
   a_nohigh: assert property (p_nohigh) else $error("both outputs high");
   // main scenarios reached
   c_temp: cover property (fault_flag_first_oe && fault_flag_second_oe);
   c_err: cover property (pslverr);
   c_dead: cover property ($fell(bridge_a_out_pos_oe));
endmodule

// ### test/hbc_host_model.sv
`timescale 1ns/1ps
module hbc_host_model
   import hbc_pkg::*;
(
   // clock and reset
   input  wire logic     clk_sys,
   input  wire logic     reset,
   // control pins
   output hbc_bridge_in_t a_out,
   output hbc_bridge_in_t b_out
);
   int up;
   // cycles since supply came up
   always @(posedge clk_sys) up <= reset ? 0 : up + 1;
   // idle pins at time zero
   initial begin
      a_out = '0;
      b_out = '0;
   end
   // apply new pin levels, then let the driver settle
   task automatic put(input hbc_bridge_in_t a, input hbc_bridge_in_t b);
      logic wake;
      wake = (a_out == 3'h0);
      while (up < STARTUP_CYC) @(posedge clk_sys);
      @(posedge clk_sys);
      a_out <= a;
      b_out <= b;
      repeat (wake ? STARTUP_CYC + 12 : 12) @(posedge clk_sys);
   endtask
endmodule

// ### test/testbench.sv
`timescale 1ns/1ps
module testbench;
   import hbc_pkg::*;
   localparam int LIM = 40000;
   logic           clk_sys, reset, psel, penable, pwrite, pready, pslverr, err;
   logic           bridge_mode_select, osc_set_pin, blank_length_select;
   logic [11:0]    paddr;
   logic [31:0]    pwdata, prdata, rd;
   logic [2:0]     flt;
   logic [1:0]     thr, pv, pe, nv, ne, fv, fe;
   hbc_bridge_in_t ia, ib;
   int             num_errors, n_checks, cyc, k, n, seed;
   logic [2:0]     fs [4] = '{3'h1, 3'h2, 3'h4, 3'h1};
   logic [1:0]     fx [4] = '{2'h2, 2'h1, 2'h3, 2'h3};
   hbc_chop_control dut_u (
      .clk_sys, .reset, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
      .bridge_mode_select, .osc_set_pin, .blank_length_select, .current_threshold(thr),
      .bridge_a_pwm(ia.pwm), .bridge_a_dir1(ia.dir1), .bridge_a_dir2(ia.dir2),
      .bridge_b_pwm(ib.pwm), .bridge_b_dir1(ib.dir1), .bridge_b_dir2(ib.dir2),
      .over_temp_fault(flt[2]), .over_current_fault(flt[1]), .open_load_fault(flt[0]),
      .bridge_a_out_pos(pv[0]), .bridge_a_out_pos_oe(pe[0]), .bridge_a_out_neg(nv[0]), .bridge_a_out_neg_oe(ne[0]),
      .bridge_b_out_pos(pv[1]), .bridge_b_out_pos_oe(pe[1]), .bridge_b_out_neg(nv[1]), .bridge_b_out_neg_oe(ne[1]),
      .fault_flag_first(fv[0]), .fault_flag_first_oe(fe[0]), .fault_flag_second(fv[1]), .fault_flag_second_oe(fe[1]));
   hbc_host_model host_u (.clk_sys, .reset, .a_out(ia), .b_out(ib));
   // 20 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   // run budget
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == LIM) begin
         num_errors++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one apb transfer, one wait state tolerated or more
   task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // expected {pos_oe, pos, neg_oe, neg} for one bridge
   function automatic logic [3:0] dec(input hbc_bridge_in_t i);
      if (!i.dir1 && !i.dir2) return 4'h0;
      if (i.pwm && i.dir1 && !i.dir2) return 4'he;
      if (i.pwm && !i.dir1) return 4'hb;
      return 4'ha;
   endfunction
   function automatic logic [3:0] got(input int i);
      return {pe[i], pe[i] & pv[i], ne[i], ne[i] & nv[i]};
   endfunction
   task automatic boot(input logic s);
      @(posedge clk_sys);
      bridge_mode_select <= s;
      reset <= 1'b1;
      repeat (10) @(posedge clk_sys);
      reset <= 1'b0;
      repeat (STARTUP_CYC + 2) @(posedge clk_sys);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd & 32'h0000_003f, {26'h0, 3'b011, s, 2'b00});
      $display("startup done, single %0d", s);
   endtask
   task automatic run_rand(input int cnt, input logic s);
      hbc_bridge_in_t x, y;
      repeat (cnt) begin
         x = 3'($random(seed));
         y = 3'($random(seed));
         if ({x, y} == 6'h0) y.dir1 = 1'b1;
         host_u.put(x, y);
         bridge_mode_select <= 1'($random(seed));
         blank_length_select <= 1'($random(seed));
         @(negedge clk_sys);
         chk(got(0), dec(x));
         chk(got(1), dec(s ? x : y));
      end
      $display("decode done, single %0d", s);
   endtask
   task automatic span(input logic [1:0] ph, output int len);
      int t0;
      do apb(1'b0, ADDR_STATUS, 32'h0); while (rd[9:8] !== ph);
      t0 = cyc;
      do apb(1'b0, ADDR_STATUS, 32'h0); while (rd[9:8] === ph);
      len = (cyc - t0 + INT_OSC_DIV / 2) / INT_OSC_DIV;
   endtask
   // main sequence
   initial begin
      seed = 32'h1d5f_ae98;
      reset = 1'b1;
      {psel, penable, pwrite, paddr, pwdata, flt, thr} = '0;
      {bridge_mode_select, osc_set_pin, blank_length_select} = '0;
      boot(1'b0);
      // register reset value, write back, read-only and unmapped places
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk(rd, {24'h0, OSC_DIV_RST});
      n = $random(seed) | 2;
      apb(1'b1, ADDR_CTRL, n);
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk(rd, n & 32'h0000_00ff);
      apb(1'b1, ADDR_STATUS, 32'hffff_ffff);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd & 32'h0000_003f, 32'h0000_0018);
      apb(1'b0, 12'h008, 32'h0);
      chk({err, rd}, {1'b1, 32'h0});
      $display("registers done");
      host_u.put(3'h0, 3'h4);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd[4], 1'b0);
      run_rand(60, 1'b0);
      // faults in rising severity, then a lower one
      host_u.put(3'h6, 3'h6);
      for (k = 0; k < 4; k++) begin
         flt <= fs[k];
         @(posedge clk_sys);
         flt <= 3'h0;
         @(posedge clk_sys);
         @(negedge clk_sys);
         chk({fv, fe, got(0)}, {2'b00, fx[k], 4'h0});
         @(posedge clk_sys);
      end
      repeat (40) @(posedge clk_sys);
      chk(fe, 2'h3);
      host_u.put(3'h0, 3'h0);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk({fe, rd[5:0]}, {2'h0, 6'h18});
      host_u.put(3'h6, 3'h0);
      @(negedge clk_sys);
      chk(got(0), 4'he);
      $display("faults done");
      // chopping spans in oscillator ticks for both blank lengths
      thr <= 2'b01;
      for (k = 0; k < 2; k++) begin
         blank_length_select <= k[0];
         span(PH_SLOW, n);
         span(PH_CHARGE, n);
         chk(n, k ? 6 : 4);
         span(PH_FAST, n);
         chk(n, 6);
         span(PH_SLOW, n);
         chk(n, k ? 4 : 6);
      end
      thr <= 2'b00;
      $display("chopping done");
      host_u.put(3'h0, 3'h0);
      boot(1'b1);
      host_u.put(3'h0, 3'h7);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd[4], 1'b1);
      run_rand(60, 1'b1);
      report_and_stop();
   end
endmodule
bind hbc_chop_control hbc_chop_control_checker chk_u (
   .clk_sys, .reset, .psel, .penable, .pready, .pslverr, .bridge_a_pwm, .bridge_a_dir1, .bridge_a_dir2,
   .bridge_a_out_pos, .bridge_a_out_pos_oe, .bridge_a_out_neg, .bridge_a_out_neg_oe, .over_temp_fault,
   .over_current_fault, .open_load_fault, .fault_flag_first, .fault_flag_first_oe, .fault_flag_second,
   .fault_flag_second_oe);
